// [include/fmc_pkg.sv]
/*
  fmc_pkg: constants for the filter mode control word.
  assumes: a single 200 MHz system clock domain.
*/
package fmc_pkg;
  localparam int MODE_W = 16;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam int BIT_SINGLE = 15;
  localparam int RATE_HI = 14;
  localparam int RATE_LO = 13;
  localparam int BIT_DECIM = 12;
  localparam int ROLE_HI = 11;
  localparam int ROLE_LO = 10;
  localparam int BIT_BANK_REG = 7;
  localparam int BIT_BANK_UP = 6;
  localparam int BIT_SWAP_ALL = 5;
  localparam int BIT_CASCADE = 4;
  localparam int RATE_DIV_MAX = 8;
  localparam int CNT_W = 3;
  typedef enum logic [1:0] {
    FMC_FULL = 2'h0, FMC_HALF = 2'h1, FMC_QUARTER = 2'h2, FMC_EIGHTH = 2'h3
  } fmc_rate_type;
  typedef enum logic [1:0] {
    FMC_INTERMEDIATE = 2'h0, FMC_INTERFACE = 2'h1,
    FMC_TERMINATION = 2'h2, FMC_STANDALONE = 2'h3
  } fmc_role_type;
endpackage

// [verilog/fmc_rate_div.sv]
/*
  fmc_rate_div: sample clock enable divider, full to one eighth.
  assumes: rate code taken from the active mode word.
*/
`timescale 1ns/1ps
module fmc_rate_div
  import fmc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] rate,
  output logic sample_en
);
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W-1:0] last;

  always_comb begin
    case (rate)
      FMC_FULL: last = 3'h0;
      FMC_HALF: last = 3'h1;
      FMC_QUARTER: last = 3'h3;
      default: last = 3'h7;
    endcase
    nxt_cnt = (cnt_ff >= last) ? 3'h0 : cnt_ff + 3'h1;
    sample_en = (cnt_ff >= last);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // a swap may raise the rate right after an eighth-rate tick
  rate_div_a: assert property (@(posedge clk) disable iff (!nrst)
    (rate == FMC_EIGHTH && sample_en) |=> (rate != FMC_EIGHTH || !sample_en) [*7])
    else $error("eighth rate enable too frequent");
  tick_gap_a: assert property (@(posedge clk) disable iff (!nrst)
    sample_en |-> ##[1:8] sample_en)
    else $error("sample enable gap longer than eighth rate");
endmodule

// [verilog/fmc_mode_reg.sv]
/*
  fmc_mode_reg: double-buffered 16-bit filter mode word with decoded outputs.
  assumes: synchronous write port and bank swap pin on clk.
*/
`timescale 1ns/1ps
// What this block does
// - one sixteen-bit word configures everything
// - after the first, writes land in pending copy only
// - bank swap toggle activates pending word
// - first write after reset goes active
// - bit15 single, else bit4 cascade
// - bits14:13 sample rate divide
// - bit12 decimate by two
// - bits11:10 chain role
// - bit7 picks pin or register bank
// - bit6 lower or upper bank
// - bit5 swaps bank every sample
// - control word select routes write here
module fmc_mode_reg
  import fmc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic wen_n,
  input wire logic control_word_select,
  input wire logic byte_mode_n,
  input wire logic byte_half_select,
  input wire logic [15:0] wdata,
  input wire logic bank_swap_pin,
  output logic [15:0] active_mode_ff,
  output logic single_filter_ff,
  output logic cascade_ff,
  output logic [1:0] rate_sel_ff,
  output logic decimate_ff,
  output logic [1:0] chain_role_ff,
  output logic upper_bank_ff,
  output logic sample_tick_ff
);
  import fmc_pkg::*;

  logic [15:0] pend_ff, nxt_pend;
  logic [15:0] nxt_active;
  logic first_ff, nxt_first;
  logic swap_req_ff, nxt_swap_req;
  logic pin_ff, nxt_pin;
  logic pin_live_ff, nxt_pin_live;
  logic bank_ff, nxt_bank;
  logic nxt_single, nxt_cascade, nxt_decim, nxt_upper;
  logic [1:0] nxt_rate, nxt_role;
  logic wr, sample_en;

  fmc_rate_div u_div (
    .clk(clk),
    .nrst(nrst),
    .rate(active_mode_ff[RATE_HI:RATE_LO]),
    .sample_en(sample_en)
  );

  // write only when both strobes low and the mode word is addressed
  assign wr = !cs_n && !wen_n && control_word_select;

  always_comb begin
    nxt_pend = pend_ff;
    nxt_active = active_mode_ff;
    nxt_first = first_ff;
    nxt_pin = bank_swap_pin;
    nxt_pin_live = 1'b1;
    nxt_swap_req = swap_req_ff;
    nxt_bank = bank_ff;
    if (wr) begin
      if (byte_mode_n) begin
        nxt_pend = wdata;
      end else if (!byte_half_select) begin
        nxt_pend[7:0] = wdata[7:0];
      end else begin
        nxt_pend[15:8] = wdata[7:0];
      end
    end
    // any level change of the pin counts as a toggle; set beats sample clear
    // pin_ff holds only its reset constant until one edge has passed, so a
    // pin resting high must not read as a toggle right after reset
    if (pin_live_ff && pin_ff != bank_swap_pin) begin
      nxt_swap_req = 1'b1;
    end else if (sample_en) begin
      nxt_swap_req = 1'b0;
    end
    if (sample_en && swap_req_ff) begin
      nxt_active = pend_ff;
    end
    // after reset, the first complete word goes live directly
    if (first_ff && wr && (byte_mode_n || byte_half_select)) begin
      nxt_active = nxt_pend;
      nxt_first = 1'b0;
    end
    // pin mode flips the bank with the same swap that loads the pending word
    if (active_mode_ff[BIT_SWAP_ALL]) begin
      if (sample_en) begin
        nxt_bank = !bank_ff;
      end
    end else if (active_mode_ff[BIT_BANK_REG]) begin
      nxt_bank = active_mode_ff[BIT_BANK_UP];
    end else if (sample_en && swap_req_ff) begin
      nxt_bank = !bank_ff;
    end
    // decoded fields lag the active word by one cycle so each output is a flop
    nxt_single = active_mode_ff[BIT_SINGLE];
    nxt_cascade = !active_mode_ff[BIT_SINGLE] && active_mode_ff[BIT_CASCADE];
    nxt_rate = active_mode_ff[RATE_HI:RATE_LO];
    nxt_decim = active_mode_ff[BIT_DECIM];
    nxt_role = active_mode_ff[ROLE_HI:ROLE_LO];
    nxt_upper = bank_ff;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_ff <= MODE_RST;
      active_mode_ff <= MODE_RST;
      first_ff <= 1'b1;
      swap_req_ff <= 1'b0;
      pin_ff <= 1'b0;
      pin_live_ff <= 1'b0;
      bank_ff <= 1'b0;
      single_filter_ff <= 1'b0;
      cascade_ff <= 1'b0;
      rate_sel_ff <= 2'h0;
      decimate_ff <= 1'b0;
      chain_role_ff <= 2'h0;
      upper_bank_ff <= 1'b0;
      sample_tick_ff <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
      active_mode_ff <= nxt_active;
      first_ff <= nxt_first;
      swap_req_ff <= nxt_swap_req;
      pin_ff <= nxt_pin;
      pin_live_ff <= nxt_pin_live;
      bank_ff <= nxt_bank;
      single_filter_ff <= nxt_single;
      cascade_ff <= nxt_cascade;
      rate_sel_ff <= nxt_rate;
      decimate_ff <= nxt_decim;
      chain_role_ff <= nxt_role;
      upper_bank_ff <= nxt_upper;
      sample_tick_ff <= sample_en;
    end
  end

  first_load_a: assert property (@(posedge clk) disable iff (!nrst)
    (first_ff && wr && byte_mode_n) |=> active_mode_ff == $past(wdata))
    else $error("first word not loaded active");
  pend_only_a: assert property (@(posedge clk) disable iff (!nrst)
    (!first_ff && !swap_req_ff) |=> $stable(active_mode_ff))
    else $error("active word changed without swap");
  swap_move_a: assert property (@(posedge clk) disable iff (!nrst)
    (swap_req_ff && sample_en && !wr) |=> active_mode_ff == $past(pend_ff))
    else $error("swap did not move pending word");
  pin_toggle_a: assert property (@(posedge clk) disable iff (!nrst)
    (pin_live_ff && pin_ff != bank_swap_pin) |=> swap_req_ff)
    else $error("pin toggle missed");
  no_write_a: assert property (@(posedge clk) disable iff (!nrst)
    (!control_word_select) |=> pend_ff == $past(pend_ff))
    else $error("pending word written without select");
  decode_mode_a: assert property (@(posedge clk) disable iff (!nrst)
    ##1 single_filter_ff == $past(active_mode_ff[BIT_SINGLE])
    && cascade_ff == ($past(active_mode_ff[BIT_CASCADE]) && !single_filter_ff))
    else $error("filter mode decode wrong");
  reg_bank_a: assert property (@(posedge clk) disable iff (!nrst)
    (active_mode_ff[BIT_BANK_REG] && !active_mode_ff[BIT_SWAP_ALL])
    |=> bank_ff == $past(active_mode_ff[BIT_BANK_UP]))
    else $error("register bank select wrong");
  swap_all_a: assert property (@(posedge clk) disable iff (!nrst)
    (active_mode_ff[BIT_SWAP_ALL] && sample_en) |=> bank_ff != $past(bank_ff))
    else $error("bank not swapped on sample");
  fields_a: assert property (@(posedge clk) disable iff (!nrst)
    ##1 rate_sel_ff == $past(active_mode_ff[14:13])
    && decimate_ff == $past(active_mode_ff[12])
    && chain_role_ff == $past(active_mode_ff[11:10]))
    else $error("rate, decimate or role decode wrong");

  // write port
  word_pend_a: assert property (@(posedge clk) disable iff (!nrst)
    (wr && byte_mode_n) |=> pend_ff == $past(wdata))
    else $error("word write not stored in pending copy");
  low_byte_a: assert property (@(posedge clk) disable iff (!nrst)
    (wr && !byte_mode_n && !byte_half_select)
    |=> pend_ff == {$past(pend_ff[15:8]), $past(wdata[7:0])})
    else $error("low byte not stored in low half");
  strobe_gate_a: assert property (@(posedge clk) disable iff (!nrst)
    (cs_n || wen_n) |=> $stable(pend_ff))
    else $error("pending word written without both strobes");

  // direct load after reset
  first_byte_a: assert property (@(posedge clk) disable iff (!nrst)
    (first_ff && wr && !byte_mode_n && byte_half_select)
    |=> active_mode_ff == {$past(wdata[7:0]), $past(pend_ff[7:0])})
    else $error("first byte-wide word not loaded active");
  first_once_a: assert property (@(posedge clk) disable iff (!nrst)
    !first_ff |=> !first_ff)
    else $error("direct load armed again without reset");

  // swap request and bank
  req_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (swap_req_ff && !sample_en) |=> swap_req_ff)
    else $error("swap request lost before sample clock");
  req_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    (swap_req_ff && sample_en && pin_ff == bank_swap_pin) |=> !swap_req_ff)
    else $error("swap request not cleared after swap");
  swap_wait_a: assert property (@(posedge clk) disable iff (!nrst)
    swap_req_ff |-> ##[0:7] sample_en)
    else $error("pending word waited too long for a sample clock");
  pin_bank_a: assert property (@(posedge clk) disable iff (!nrst)
    (!active_mode_ff[BIT_BANK_REG] && !active_mode_ff[BIT_SWAP_ALL]
    && sample_en && swap_req_ff) |=> bank_ff != $past(bank_ff))
    else $error("pin swap did not flip the bank");
  pin_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (!active_mode_ff[BIT_BANK_REG] && !active_mode_ff[BIT_SWAP_ALL]
    && !(sample_en && swap_req_ff)) |=> $stable(bank_ff))
    else $error("pin mode bank changed without swap");
endmodule

// [bench/fmc_host_model.sv]
/*
  fmc_host_model: remote host master writing the mode word.
  assumes: write port sampled on the rising edge of clk.
*/
`timescale 1ns/1ps
module fmc_host_model (
  input wire logic clk,
  output logic cs_n,
  output logic wen_n,
  output logic control_word_select,
  output logic byte_mode_n,
  output logic byte_half_select,
  output logic [15:0] wdata
);
  initial begin
    cs_n = 1'h1;
    wen_n = 1'h1;
    control_word_select = 1'h0;
    byte_mode_n = 1'h1;
    byte_half_select = 1'h0;
    wdata = 16'h0000;
  end
  task automatic put(input logic sel, input logic h, input logic [15:0] d);
    cs_n <= 1'h0;
    wen_n <= 1'h0;
    control_word_select <= sel;
    byte_half_select <= h;
    wdata <= d;
    @(posedge clk);
  endtask
  // caller keeps reserved bits clear
  task automatic wr(input logic sel, input logic bm, input logic [15:0] d);
    @(posedge clk);
    byte_mode_n <= bm;
    if (bm) put(sel, 1'h0, d);
    else begin
      put(sel, 1'h0, {8'h00, d[7:0]});
      put(sel, 1'h1, {8'h00, d[15:8]});
    end
    wen_n <= 1'h1;
    repeat (2) @(posedge clk);
    cs_n <= 1'h1;
    // released bus must not look like held data
    wdata <= ~wdata;
    @(posedge clk);
  endtask
endmodule

// [bench/fmc_mode_reg_tb.sv]
/*
  fmc_mode_reg_tb: random mode words, pending/active model, decode checks.
  assumes: fmc_host_model drives the write port.
*/
`timescale 1ns/1ps
module fmc_mode_reg_tb;
  import fmc_pkg::*;
  logic clk, nrst, cs_n, wen_n, sel_w, bm_n, half, pin, single, casc, decim, upper, tick;
  logic [15:0] wdata, active;
  logic [1:0] rate, role;
  int num_errors, compares, seed, pend, act, d, n, bank;
  logic sel;
  fmc_host_model host (.clk(clk), .cs_n(cs_n), .wen_n(wen_n), .control_word_select(sel_w),
    .byte_mode_n(bm_n), .byte_half_select(half), .wdata(wdata));
  fmc_mode_reg uut (.clk(clk), .nrst(nrst), .cs_n(cs_n), .wen_n(wen_n),
    .control_word_select(sel_w), .byte_mode_n(bm_n), .byte_half_select(half),
    .wdata(wdata), .bank_swap_pin(pin), .active_mode_ff(active), .single_filter_ff(single),
    .cascade_ff(casc), .rate_sel_ff(rate), .decimate_ff(decim), .chain_role_ff(role),
    .upper_bank_ff(upper), .sample_tick_ff(tick));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic dec();
    logic prev;
    int m;
    chk({single, casc, rate, decim, role, 9'h0},
      {act[15], !act[15] & act[4], act[14:13], act[12], act[11:10], 9'h0});
    if (!act[5]) chk({15'h0, upper}, 16'(bank));
    n = 0;
    m = 0;
    prev = upper;
    repeat (16) begin
      @(posedge clk);
      #1 n += int'(tick);
      m += int'(upper != prev);
      prev = upper;
    end
    chk(16'(n), 16'(16 >> act[14:13]));
    chk(16'(m), act[5] ? 16'(16 >> act[14:13]) : 16'h0);
  endtask
  task automatic boot(input logic bm);
    nrst <= 1'h0;
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    // reserved bits and bit 5 kept clear
    d = $random(seed) & 16'hfcd0;
    host.wr(1'h1, bm, 16'(d));
    act = d;
    pend = d;
    bank = act[7] ? act[6] : 0;
    #1 chk(active, 16'(act));
    dec();
  endtask
  task give_verdict;
    $display("num_errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end
  initial begin
    seed = 40194;
    num_errors = 0;
    compares = 0;
    pin = 1'h0;
    boot(1'h1);
    for (int i = 0; i < 25; i++) begin
      d = $random(seed) & 16'hfcd0;
      // last pass sets bit 5, which the writer may do
      if (i == 24) d |= 32'h20;
      // every fourth write goes to coefficient space
      sel = (i % 4 != 3);
      host.wr(sel, 1'(i % 2), 16'(d));
      if (sel) pend = d;
      #1 chk(active, 16'(act));
      @(posedge clk) pin <= ~pin;
      repeat (12) @(posedge clk);
      if (!act[7] && !act[5]) bank ^= 1;
      act = pend;
      if (act[7]) bank = act[6];
      #1 chk(active, 16'(act));
      dec();
    end
    // second reset with the pin resting high must arm the direct load again
    @(posedge clk);
    boot(1'h0);
    give_verdict();
  end
endmodule
